// ==== common/rsfr_pkg.sv ====
// Package with register offsets, field layouts and reset values of the rail status bank.
package rsfr_pkg;

    // Register address width and data width of the internal register port.
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // Register offsets.
    localparam logic [7:0] OFS_POWER_GOOD_LIVE_B = 8'hB1;
    localparam logic [7:0] OFS_RAIL_FAULT_LATCH_A = 8'hB2;
    localparam logic [7:0] OFS_RAIL_FAULT_LATCH_B = 8'hB3;
    localparam logic [7:0] OFS_CRITICAL_TEMP_FLAGS = 8'hB4;

    // Reset values.
    localparam logic [7:0] RST_POWER_GOOD_LIVE_B = 8'h00;
    localparam logic [7:0] RST_RAIL_FAULT_LATCH_A = 8'h00;
    localparam logic [7:0] RST_RAIL_FAULT_LATCH_B = 8'h00;
    localparam logic [7:0] RST_CRITICAL_TEMP_FLAGS = 8'h00;

    // Implemented bits of each register; the rest are reserved and read zero.
    localparam logic [7:0] MASK_POWER_GOOD_LIVE_B = 8'h3F;
    localparam logic [7:0] MASK_RAIL_FAULT_LATCH_A = 8'hFF;
    localparam logic [7:0] MASK_RAIL_FAULT_LATCH_B = 8'h1F;
    localparam logic [7:0] MASK_CRITICAL_TEMP_FLAGS = 8'h1F;

    // Field widths.
    localparam int unsigned PG_W = 6;
    localparam int unsigned FLTA_W = 8;
    localparam int unsigned FLTB_W = 5;
    localparam int unsigned TEMP_W = 5;

    // Power-good field positions in the second power-good register.
    localparam int unsigned POS_FIXED_5V_IN_REGULATION = 5;
    localparam int unsigned POS_AUX1_IN_REGULATION = 4;
    localparam int unsigned POS_TERMINATION_IN_REGULATION = 3;
    localparam int unsigned POS_SWITCH_B2_IN_REGULATION = 2;
    localparam int unsigned POS_SWITCH_B1_IN_REGULATION = 1;
    localparam int unsigned POS_AUX3_IN_REGULATION = 0;

    // Lost-regulation flag positions in the first fault latch.
    localparam int unsigned POS_FLT_AUX_REGULATOR_2 = 7;
    localparam int unsigned POS_FLT_SWITCH_A1 = 6;
    localparam int unsigned POS_FLT_STEPDOWN_6 = 5;
    localparam int unsigned POS_FLT_STEPDOWN_5 = 4;
    localparam int unsigned POS_FLT_STEPDOWN_4 = 3;
    localparam int unsigned POS_FLT_STEPDOWN_3 = 2;
    localparam int unsigned POS_FLT_STEPDOWN_2 = 1;
    localparam int unsigned POS_FLT_STEPDOWN_1 = 0;

    // Lost-regulation flag positions in the second fault latch.
    localparam int unsigned POS_FLT_AUX_REGULATOR_1 = 4;
    localparam int unsigned POS_FLT_TERMINATION_REGULATOR = 3;
    localparam int unsigned POS_FLT_SWITCH_B2 = 2;
    localparam int unsigned POS_FLT_SWITCH_B1 = 1;
    localparam int unsigned POS_FLT_AUX_REGULATOR_3 = 0;

    // Over-temperature flag positions in the critical temperature register.
    localparam int unsigned POS_DIE_BODY_OVERTEMP = 4;
    localparam int unsigned POS_TERMINATION_OVERTEMP = 3;
    localparam int unsigned POS_UPPER_RIGHT_OVERTEMP = 2;
    localparam int unsigned POS_UPPER_LEFT_OVERTEMP = 1;
    localparam int unsigned POS_LOWER_RIGHT_OVERTEMP = 0;

    // Width of all status inputs taken through the synchroniser together.
    localparam int unsigned SYNC_W = PG_W + FLTA_W + FLTB_W + TEMP_W;

endpackage

// ==== hdl/rail_status_fault_regs.sv ====
// Rail power-good, lost-regulation and critical temperature status register bank.
`timescale 1ns/100ps
`default_nettype none

module rail_status_fault_regs (
    input wire logic clk_sys, // System clock, 100 MHz.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire logic [rsfr_pkg::ADDR_W-1:0] regAddr, // Register offset of the access.
    input wire logic regWrEn, // One-cycle write strobe.
    input wire logic [rsfr_pkg::DATA_W-1:0] regWrData, // Write data.
    input wire logic regRdEn, // One-cycle read strobe.
    output logic [rsfr_pkg::DATA_W-1:0] regRdData, // Registered read data.
    output logic regRdValid, // One-cycle pulse marking read data.
    input wire logic [rsfr_pkg::PG_W-1:0] pgoodRaw, // Live in-regulation levels.
    input wire logic [rsfr_pkg::FLTA_W-1:0] lostRegRawA, // Lost-regulation levels, group A.
    input wire logic [rsfr_pkg::FLTB_W-1:0] lostRegRawB, // Lost-regulation levels, group B.
    input wire logic [rsfr_pkg::TEMP_W-1:0] overtempRaw // Above-critical levels of sensors.
);
    import rsfr_pkg::*;

    logic [SYNC_W-1:0] rawAll; // All analog levels packed for the synchroniser.
    logic [SYNC_W-1:0] syncAll; // Synchronised copy of rawAll.
    logic [PG_W-1:0] pgoodSync; // Synchronised power-good levels.
    logic [FLTA_W-1:0] lostRegA; // Synchronised lost-regulation levels, group A.
    logic [FLTB_W-1:0] lostRegB; // Synchronised lost-regulation levels, group B.
    logic [TEMP_W-1:0] overtemp; // Synchronised over-temperature levels.

    logic [7:0] pgLive_q; // Live power-good register image.
    logic [7:0] pgLive_d; // Next value of pgLive_q.
    logic [7:0] faultA_q; // First fault latch.
    logic [7:0] faultA_d; // Next value of faultA_q.
    logic [7:0] faultB_q; // Second fault latch.
    logic [7:0] faultB_d; // Next value of faultB_q.
    logic [7:0] critical_temp_flags_q; // Critical temperature flags.
    logic [7:0] critical_temp_flags_d; // Next value of critical_temp_flags_q.
    logic [7:0] rdData_q; // Read data register.
    logic [7:0] rdData_d; // Next value of rdData_q.
    logic rdValid_q; // Read valid pulse register.
    logic rdValid_d; // Next value of rdValid_q.

    // Sticky flag update: new events set, host ones clear, set beats clear.
    function automatic logic [7:0] stickyNext(
        input logic [7:0] cur,
        input logic [7:0] setBits,
        input logic clrEn,
        input logic [7:0] clrBits,
        input logic [7:0] mask
    );
        logic [7:0] clr;
        clr = clrEn ? clrBits : 8'h00;
        stickyNext = ((cur & ~clr) | setBits) & mask;
    endfunction

    // The status levels come from analog comparators on no clock, so they are
    // synchronised before any flag logic sees them.
    assign rawAll = {pgoodRaw, lostRegRawA, lostRegRawB, overtempRaw};

    rsfr_sync #(
        .WIDTH(SYNC_W)
    ) uSync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .asyncIn(rawAll),
        .syncOut(syncAll)
    );

    // Unpack the synchronised levels in the same order they were packed.
    assign pgoodSync = syncAll[SYNC_W-1 -: PG_W];
    assign lostRegA = syncAll[FLTB_W+TEMP_W +: FLTA_W];
    assign lostRegB = syncAll[TEMP_W +: FLTB_W];
    assign overtemp = syncAll[0 +: TEMP_W];

    // Next values of the status registers and of the read answer.
    always_comb begin
        // Power-good bits simply track the rails; there is deliberately no
        // latching, so a glitching rail shows up only if read at that moment.
        pgLive_d = 8'h00;
        pgLive_d[POS_FIXED_5V_IN_REGULATION] = pgoodSync[POS_FIXED_5V_IN_REGULATION];
        pgLive_d[POS_AUX1_IN_REGULATION] = pgoodSync[POS_AUX1_IN_REGULATION];
        pgLive_d[POS_TERMINATION_IN_REGULATION] =
            pgoodSync[POS_TERMINATION_IN_REGULATION];
        pgLive_d[POS_SWITCH_B2_IN_REGULATION] = pgoodSync[POS_SWITCH_B2_IN_REGULATION];
        pgLive_d[POS_SWITCH_B1_IN_REGULATION] = pgoodSync[POS_SWITCH_B1_IN_REGULATION];
        pgLive_d[POS_AUX3_IN_REGULATION] = pgoodSync[POS_AUX3_IN_REGULATION];
        pgLive_d = pgLive_d & MASK_POWER_GOOD_LIVE_B;

        // Fault latches: a rail still out of regulation keeps its flag set.
        faultA_d = stickyNext(faultA_q, lostRegA, regWrEn &&
            (regAddr == OFS_RAIL_FAULT_LATCH_A), regWrData, MASK_RAIL_FAULT_LATCH_A);
        faultB_d = stickyNext(faultB_q, {3'h0, lostRegB}, regWrEn &&
            (regAddr == OFS_RAIL_FAULT_LATCH_B), regWrData, MASK_RAIL_FAULT_LATCH_B);
        critical_temp_flags_d = stickyNext(critical_temp_flags_q, {3'h0, overtemp}, regWrEn &&
            (regAddr == OFS_CRITICAL_TEMP_FLAGS), regWrData,
            MASK_CRITICAL_TEMP_FLAGS);

        // Read decode; an unmapped offset answers zero rather than stalling.
        rdValid_d = regRdEn;
        rdData_d = rdData_q;
        if (regRdEn) begin
            case (regAddr)
                OFS_POWER_GOOD_LIVE_B: begin
                    rdData_d = pgLive_q;
                end
                OFS_RAIL_FAULT_LATCH_A: begin
                    rdData_d = faultA_q;
                end
                OFS_RAIL_FAULT_LATCH_B: begin
                    rdData_d = faultB_q;
                end
                OFS_CRITICAL_TEMP_FLAGS: begin
                    rdData_d = critical_temp_flags_q;
                end
                default: begin
                    rdData_d = 8'h00;
                end
            endcase
        end

        // Reset clears everything: no fault, no over-temperature, no power good.
        if (sys_rst) begin
            pgLive_d = RST_POWER_GOOD_LIVE_B;
            faultA_d = RST_RAIL_FAULT_LATCH_A;
            faultB_d = RST_RAIL_FAULT_LATCH_B;
            critical_temp_flags_d = RST_CRITICAL_TEMP_FLAGS;
            rdData_d = 8'h00;
            rdValid_d = 1'b0;
        end
    end

    // Register stage for all status state and the read answer.
    always_ff @(posedge clk_sys) begin
        pgLive_q <= pgLive_d;
        faultA_q <= faultA_d;
        faultB_q <= faultB_d;
        critical_temp_flags_q <= critical_temp_flags_d;
        rdData_q <= rdData_d;
        rdValid_q <= rdValid_d;
    end

    // Outputs come straight from flip-flops.
    assign regRdData = rdData_q;
    assign regRdValid = rdValid_q;

endmodule

`default_nettype wire

// ==== hdl/rsfr_sync.sv ====
// Two-stage synchroniser for a vector of asynchronous status levels.
`timescale 1ns/100ps
`default_nettype none

module rsfr_sync #(
    parameter int unsigned WIDTH = 24 // Number of levels carried across.
) (
    input wire logic clk_sys, // System clock.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire logic [WIDTH-1:0] asyncIn, // Levels from the analog side.
    output logic [WIDTH-1:0] syncOut // Levels safe to read on clk_sys.
);

    logic [WIDTH-1:0] meta_q; // First stage; only the second stage reads it.
    logic [WIDTH-1:0] meta_d; // Next value of the first stage.
    logic [WIDTH-1:0] stable_q; // Second stage.
    logic [WIDTH-1:0] stable_d; // Next value of the second stage.

    // Next values: the first stage samples the pins, the second the first stage.
    // The first stage takes the raw levels with no gate in front of it, so no
    // logic ever looks at a level that may still be settling; reset clears only
    // the second stage, and the first refills from the pins within one edge.
    always_comb begin
        meta_d = asyncIn;
        stable_d = meta_q;
        if (sys_rst) begin
            stable_d = '0;
        end
    end

    // Both stages register on every edge; reset is folded into the next values.
    always_ff @(posedge clk_sys) begin
        meta_q <= meta_d;
        stable_q <= stable_d;
    end

    assign syncOut = stable_q;

endmodule

`default_nettype wire

// ==== test/rsfr_host_model.sv ====
// Host controller model that reads and clears the status bank over its byte port.
`timescale 1ns/100ps
`default_nettype none
module rsfr_host_model (
    input wire logic clk_sys, // System clock.
    output logic [rsfr_pkg::ADDR_W-1:0] regAddr, // Register offset.
    output logic regWrEn, // Write strobe.
    output logic [rsfr_pkg::DATA_W-1:0] regWrData, // Write data.
    output logic regRdEn, // Read strobe.
    input wire logic [rsfr_pkg::DATA_W-1:0] regRdData, // Read data.
    input wire logic regRdValid // Read data marker.
);
    import rsfr_pkg::*;
    initial {regAddr, regWrEn, regWrData, regRdEn} = '0;
    // Ones in the data clear flags; idle lines are scrambled so stale values are never trusted.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk_sys);
        regWrEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask
    // The valid marker stands for one cycle while the data holds, so both are taken at the falling edge after the strobe.
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk_sys);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk_sys);
        d = regRdData;
        v = regRdValid;
        regRdEn = 1'b0;
        regAddr = ~a;
    endtask
endmodule
`default_nettype wire

// ==== test/rsfr_monitor.sv ====
// Port checker of the rail status bank.
`timescale 1ns/100ps
`default_nettype none
module rsfr_monitor (
    input wire logic clk_sys, // Clock.
    input wire logic sys_rst, // Reset.
    input wire logic [rsfr_pkg::ADDR_W-1:0] regAddr, // Offset.
    input wire logic regWrEn, // Write strobe.
    input wire logic [rsfr_pkg::DATA_W-1:0] regWrData, // Write data.
    input wire logic regRdEn, // Read strobe.
    input wire logic [rsfr_pkg::DATA_W-1:0] regRdData, // Read data.
    input wire logic regRdValid, // Read marker.
    input wire logic [rsfr_pkg::PG_W-1:0] pgoodRaw, // Power-good levels.
    input wire logic [rsfr_pkg::FLTA_W-1:0] lostRegRawA, // Fault levels A.
    input wire logic [rsfr_pkg::FLTB_W-1:0] lostRegRawB, // Fault levels B.
    input wire logic [rsfr_pkg::TEMP_W-1:0] overtempRaw // Sensor levels.
);
    import rsfr_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // A level only counts once it stood for five samples, which covers the synchroniser lag.
    logic [23:0] allRaw, held, anyRaw, d_q [4];
    logic [2:0] age_q; // Cycles since reset, saturating.
    logic [7:0] heldA;
    logic [4:0] heldB, heldT;
    assign allRaw = {pgoodRaw, lostRegRawA, lostRegRawB, overtempRaw};
    assign held = allRaw & d_q[0] & d_q[1] & d_q[2] & d_q[3];
    assign anyRaw = allRaw | d_q[0] | d_q[1] | d_q[2] | d_q[3];
    assign {heldA, heldB, heldT} = held[17:0];
    always_ff @(posedge clk_sys) begin
        d_q <= '{allRaw, d_q[0], d_q[1], d_q[2]};
        age_q <= sys_rst ? 3'h0 : age_q + 3'(age_q != 3'h7);
    end
    AST_RD_ANSWER: assert property (regRdEn |=> regRdValid) else $error("read unanswered");
    AST_NO_SPURIOUS: assert property (!regRdEn |=> !regRdValid) else $error("stray valid");
    AST_RESET_ZERO: assert property (disable iff (1'b0) sys_rst |=> regRdData == 8'h00)
        else $error("reset value");
    AST_PG_LIVE: assert property (regRdEn && regAddr == OFS_POWER_GOOD_LIVE_B
        && held[23:18] == anyRaw[23:18] && age_q == 3'h7
        |=> regRdData == {2'b00, $past(pgoodRaw)}) else $error("power-good wrong");
    AST_SET_A: assert property (regRdEn && regAddr == OFS_RAIL_FAULT_LATCH_A && age_q == 3'h7
        |=> (regRdData & $past(heldA)) == $past(heldA)) else $error("fault A lost");
    AST_SET_B: assert property (regRdEn && regAddr == OFS_RAIL_FAULT_LATCH_B && age_q == 3'h7
        |=> {regRdData[7:5], regRdData[4:0] & $past(heldB)} == {3'h0, $past(heldB)})
        else $error("fault B wrong");
    AST_SET_T: assert property (regRdEn && regAddr == OFS_CRITICAL_TEMP_FLAGS && age_q == 3'h7
        |=> {regRdData[7:5], regRdData[4:0] & $past(heldT)} == {3'h0, $past(heldT)})
        else $error("temperature wrong");
    AST_UNMAPPED: assert property (regRdEn && (regAddr < OFS_POWER_GOOD_LIVE_B
        || regAddr > OFS_CRITICAL_TEMP_FLAGS) |=> regRdData == 8'h00) else $error("unmapped read");
    cover property (regRdEn && regAddr == OFS_RAIL_FAULT_LATCH_A && |heldA);
    cover property (regWrEn && regAddr == OFS_CRITICAL_TEMP_FLAGS && |heldT);
    cover property (regRdEn && regAddr == OFS_POWER_GOOD_LIVE_B && |pgoodRaw);
endmodule
bind rail_status_fault_regs rsfr_monitor i_mon (.clk_sys, .sys_rst, .regAddr, .regWrEn, .regWrData,
    .regRdEn, .regRdData, .regRdValid, .pgoodRaw, .lostRegRawA, .lostRegRawB, .overtempRaw);
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench of the status bank driven through the host model.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import rsfr_pkg::*;
    logic clk_sys = 1'b0; // Clock.
    logic sys_rst = 1'b1; // Reset.
    logic [7:0] regAddr, regWrData, regRdData, lostRegRawA = 8'h00, flags, w, a, m; // Port, state.
    logic regWrEn, regRdEn, regRdValid; // Strobes.
    logic [5:0] pgoodRaw = 6'h00; // Power-good levels.
    logic [4:0] lostRegRawB = 5'h00, overtempRaw = 5'h00; // Fault and sensor levels.
    int mismatches = 0, checked = 0; // Tallies.
    initial forever #5 clk_sys = ~clk_sys;
    rail_status_fault_regs i_dut (.clk_sys, .sys_rst, .regAddr, .regWrEn, .regWrData, .regRdEn,
        .regRdData, .regRdValid, .pgoodRaw, .lostRegRawA, .lostRegRawB, .overtempRaw);
    rsfr_host_model i_host (.clk_sys, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData,
        .regRdValid);
    // Flags left after a clear while the levels in set still stand.
    function automatic logic [7:0] after_clr(logic [7:0] c, logic [7:0] d, logic [7:0] s,
        logic [7:0] msk);
        return ((c & ~d) | s) & msk;
    endfunction
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(logic [7:0] adr, logic [7:0] exp);
        logic [7:0] d;
        logic v;
        i_host.rd(adr, d, v);
        chk({7'h00, v}, 8'h01);
        chk(d, exp);
    endtask
    // Group 0 is power-good, 1 and 2 the fault groups, 3 the sensors.
    task automatic drive(int g, logic [7:0] v);
        @(negedge clk_sys);
        case (g)
            0: pgoodRaw = v[5:0];
            1: lostRegRawA = v;
            2: lostRegRawB = v[4:0];
            default: overtempRaw = v[4:0];
        endcase
    endtask
    task automatic conclude();
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        void'($urandom(48389));
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'b0;
        for (int k = 0; k < 6; k++) rd_chk(8'hB0 + 8'(k), 8'h00);
        // Corners first, then random patterns; each read follows an ignored write.
        for (int i = 0; i < 8; i++) begin
            w = (i == 0) ? 8'h3F : (i == 1) ? 8'h00 : 8'($urandom);
            drive(0, w);
            repeat (4) @(posedge clk_sys);
            i_host.wr(OFS_POWER_GOOD_LIVE_B, 8'hFF);
            rd_chk(OFS_POWER_GOOD_LIVE_B, w & MASK_POWER_GOOD_LIVE_B);
        end
        for (int g = 1; g < 4; g++) begin
            m = g == 1 ? MASK_RAIL_FAULT_LATCH_A : g == 2 ? MASK_RAIL_FAULT_LATCH_B :
                MASK_CRITICAL_TEMP_FLAGS;
            a = OFS_POWER_GOOD_LIVE_B + 8'(g);
            flags = (g == 1 ? 8'hFF : 8'($urandom)) & m;
            drive(g, flags);
            drive(g, 8'h00);
            repeat (4) @(posedge clk_sys);
            rd_chk(a, flags);
            i_host.wr(a, 8'h00);
            rd_chk(a, flags);
            w = 8'($urandom) | 8'hE0;
            i_host.wr(a, w);
            rd_chk(a, after_clr(flags, w, 8'h00, m));
            drive(g, 8'hFF);
            repeat (4) @(posedge clk_sys);
            i_host.wr(a, 8'hFF);
            rd_chk(a, after_clr(8'h00, 8'hFF, 8'hFF, m));
            drive(g, 8'h00);
            repeat (4) @(posedge clk_sys);
            i_host.wr(a, 8'hFF);
            rd_chk(a, 8'h00);
        end
        conclude();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        mismatches++;
        conclude();
    end
endmodule
`default_nettype wire
